// *** vref_ctrl_defs.vh ***
// constants for the reference and primary control register logic
// Overview of operation
// - high reference byte, 8 mV per count, read/write, resets to 0x3e
// - 11-bit code: high byte in bits 10:3, low field in 2:0
// - code is plain unsigned binary; bits 15:11 not implemented
// - slew select 00/01/10/11 = 38/50/75/150 mV/ms, after soft-start only
// - forced discharge bit 1 keeps discharge on; 0 releases it
// - discharge also on for overvoltage (discharge mode) and input lockout
// - discharge on while update trigger set, off 20 ms after it clears
// - dither bit enables spread spectrum; resets to 0
// - hold select 0: power-good flag clears when output back in window
// - hold select 1: power-good flag latches once output leaves window
// - low field 3 bits, 1 mV per count, resets to 100
// - host writes reference then trigger; device clears trigger at target
`ifndef VREF_CTRL_DEFS_VH
`define VREF_CTRL_DEFS_VH
`define ADDR_REF_LOW 8'h00
`define ADDR_REF_HIGH 8'h01
`define ADDR_CTRL1 8'h02
`define RST_REF_LOW 3'h4
`define RST_REF_HIGH 8'h3e
`define RST_CTRL1 8'h40
`define CTRL1_SLEW_HI 7
`define CTRL1_SLEW_LO 6
`define CTRL1_OUTPUT_DISCHARGE_FORCE 5
`define CTRL1_DITHER 4
`define CTRL1_PG_HOLD 3
`define CTRL1_RSVD 2
`define CTRL1_GO 1
`define CTRL1_SW_EN 0
`define CLK_MHZ 200
`define SLEW_38_UV_PER_MS 38000
`define SLEW_50_UV_PER_MS 50000
`define SLEW_75_UV_PER_MS 75000
`define SLEW_150_UV_PER_MS 150000
`define DISCH_HOLD_MS 20
`endif

// *** vref_ctrl_regs.v ***
// reference code and primary control register bank
`timescale 1ns/1ps
`include "vref_ctrl_defs.vh"
module vref_ctrl_regs #(
  // cycles per 1 mV step at each slew rate: 1e6 ns/ms * 1000 uV / rate_uv / 5 ns
  parameter STEP_38 = (`CLK_MHZ * 1000000) / `SLEW_38_UV_PER_MS,
  parameter STEP_50 = (`CLK_MHZ * 1000000) / `SLEW_50_UV_PER_MS,
  parameter STEP_75 = (`CLK_MHZ * 1000000) / `SLEW_75_UV_PER_MS,
  parameter STEP_150 = (`CLK_MHZ * 1000000) / `SLEW_150_UV_PER_MS,
  parameter DISCH_HOLD = `DISCH_HOLD_MS * `CLK_MHZ * 1000
)(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_r,
  // analog status inputs
  input wire soft_start_done,
  input wire output_overvoltage_fault,
  input wire overvoltage_response_select,
  input wire input_undervoltage_lockout,
  input wire pg_out_of_window,
  // control outputs
  output reg [10:0] vref_target_r,
  output reg [10:0] vref_active_r,
  output reg [1:0] ref_slew_select_r,
  output reg output_discharge_force_r,
  output reg dither_enable_r,
  output reg power_good_hold_select_r,
  output reg start_reserved_r,
  output reg switching_enable_r,
  output reg update_busy_r,
  output reg discharge_on_r,
  output reg power_good_flag_r
);

  reg [2:0] ref_low_r;
  reg [7:0] ref_high_r;
  reg [23:0] step_cnt_r;
  reg [23:0] hold_cnt_r;
  reg [23:0] step_len;
  wire [10:0] code;
  wire step_tick;
  wire wr_go;

  assign code = {ref_high_r, ref_low_r};
  assign wr_go = wr_en && addr == `ADDR_CTRL1 && wdata[`CTRL1_GO];

  always @*
  begin
    case (ref_slew_select_r)
      2'b00: step_len = STEP_38[23:0];
      2'b01: step_len = STEP_50[23:0];
      2'b10: step_len = STEP_75[23:0];
      default: step_len = STEP_150[23:0];
    endcase
  end

  // before soft-start ends the ramp is owned by soft-start, so step each clk
  assign step_tick = !soft_start_done || step_cnt_r >= step_len - 24'h1;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ref_low_r <= `RST_REF_LOW;
      ref_high_r <= `RST_REF_HIGH;
      ref_slew_select_r <= 2'b01;
      output_discharge_force_r <= 1'b0;
      dither_enable_r <= 1'b0;
      power_good_hold_select_r <= 1'b0;
      start_reserved_r <= 1'b0;
      switching_enable_r <= 1'b0;
      update_busy_r <= 1'b0;
      rdata_r <= 8'h00;
      vref_active_r <= {`RST_REF_HIGH, `RST_REF_LOW};
      vref_target_r <= {`RST_REF_HIGH, `RST_REF_LOW};
      step_cnt_r <= 24'h0;
      hold_cnt_r <= 24'h0;
      discharge_on_r <= 1'b0;
      power_good_flag_r <= 1'b0;
    end
    else
    begin
      if (wr_en)
      begin
        case (addr)
          `ADDR_REF_LOW: ref_low_r <= wdata[2:0];
          `ADDR_REF_HIGH: ref_high_r <= wdata;
          `ADDR_CTRL1:
          begin
            ref_slew_select_r <=
              wdata[`CTRL1_SLEW_HI:`CTRL1_SLEW_LO];
            output_discharge_force_r <= wdata[`CTRL1_OUTPUT_DISCHARGE_FORCE];
            dither_enable_r <= wdata[`CTRL1_DITHER];
            power_good_hold_select_r <= wdata[`CTRL1_PG_HOLD];
            start_reserved_r <= wdata[`CTRL1_RSVD];
            switching_enable_r <= wdata[`CTRL1_SW_EN];
          end
          default: ;
        endcase
      end
      if (rd_en)
      begin
        case (addr)
          `ADDR_REF_LOW: rdata_r <= {5'h00, ref_low_r};
          `ADDR_REF_HIGH: rdata_r <= ref_high_r;
          `ADDR_CTRL1: rdata_r <= {ref_slew_select_r,
            output_discharge_force_r, dither_enable_r,
            power_good_hold_select_r, start_reserved_r,
            update_busy_r, switching_enable_r};
          default: rdata_r <= 8'h00;
        endcase
      end
      // new write of the trigger wins over self-clear
      if (wr_go)
      begin
        update_busy_r <= 1'b1;
        vref_target_r <= code;
        step_cnt_r <= 24'h0;
      end
      else if (update_busy_r)
      begin
        if (vref_active_r == vref_target_r)
          update_busy_r <= 1'b0;
        else if (step_tick)
        begin
          step_cnt_r <= 24'h0;
          // one count per step, so the ramp cannot overshoot
          if (vref_active_r < vref_target_r)
            vref_active_r <= vref_active_r + 11'h1;
          else
            vref_active_r <= vref_active_r - 11'h1;
        end
        else
          step_cnt_r <= step_cnt_r + 24'h1;
      end
      // discharge hold restarts on every trigger, ends 20 ms after clear
      if (update_busy_r || wr_go)
        hold_cnt_r <= DISCH_HOLD[23:0];
      else if (hold_cnt_r != 24'h0)
        hold_cnt_r <= hold_cnt_r - 24'h1;
      discharge_on_r <= output_discharge_force_r
        || (output_overvoltage_fault && overvoltage_response_select)
        || input_undervoltage_lockout
        || update_busy_r || hold_cnt_r != 24'h0;
      if (pg_out_of_window)
        power_good_flag_r <= 1'b1;
      else if (!power_good_hold_select_r)
        power_good_flag_r <= 1'b0;
      // hold select 1: flag stays set once raised
      else
        power_good_flag_r <= power_good_flag_r;
    end
  end

endmodule

// *** vref_ctrl_regs_assertions.sv ***
// checker for the reference and control register bank
`timescale 1ns/1ps
module vref_ctrl_chk (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // watched ports
  input wire pg_out_of_window,
  input wire [10:0] vref_target_r,
  input wire [10:0] vref_active_r,
  input wire output_discharge_force_r,
  input wire power_good_hold_select_r,
  input wire update_busy_r,
  input wire discharge_on_r,
  input wire power_good_flag_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hold;
    power_good_hold_select_r && power_good_flag_r ##1 power_good_hold_select_r;
  endsequence
  a_force_disch: assert property (output_discharge_force_r [*2] |->
    discharge_on_r) else $error("forced discharge off");
  a_busy_disch: assert property (update_busy_r [*2] |->
    discharge_on_r) else $error("discharge off in update");
  a_disch_hold: assert property ($fell(update_busy_r) |->
    discharge_on_r [*8]) else $error("discharge hold short");
  a_step_size: assert property ($changed(vref_active_r) |->
    vref_active_r - $past(vref_active_r) == 11'h1 ||
    $past(vref_active_r) - vref_active_r == 11'h1) else $error("bad step");
  a_ref_idle: assert property (!update_busy_r |->
    ##1 $stable(vref_active_r)) else $error("reference moved idle");
  a_busy_done: assert property (update_busy_r &&
    vref_active_r == vref_target_r |=> !update_busy_r) else $error("busy");
  a_pg_follow: assert property ((!power_good_hold_select_r &&
    !pg_out_of_window) [*2] |-> !power_good_flag_r) else $error("flag kept");
  a_pg_latch: assert property (s_hold |-> power_good_flag_r)
    else $error("flag not latched");
endmodule
bind vref_ctrl_regs vref_ctrl_chk u_chk (.clk, .rst_n, .pg_out_of_window,
  .vref_target_r, .vref_active_r, .output_discharge_force_r,
  .power_good_hold_select_r, .update_busy_r, .discharge_on_r,
  .power_good_flag_r);

// *** vref_ctrl_host.sv ***
// host model for the register write and read port
`timescale 1ns/1ps
module vref_ctrl_host (
  // clock
  input wire clk,
  // register port
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire [7:0] rdata_r
);
  logic [7:0] q;
  initial {wr_en, rd_en, addr, wdata} = 18'h0;
  // quiet cycle after each access keeps strobes apart
  task xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= we;
    rd_en <= !we;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    wdata <= ~d;
    @(posedge clk) #1;
    q = rdata_r;
  endtask
endmodule

// *** vref_ctrl_regs_test.sv ***
// test of the reference and control register bank
`timescale 1ns/1ps
module vref_ctrl_regs_test;
  logic clk = 1'b0, rst_n = 1'b0, ssd = 1'b1, pgw = 1'b0;
  logic [2:0] flt = 3'h0;
  wire wr_en, rd_en;
  wire [7:0] addr, wdata, rdata_r;
  int num_errors = 0, checks = 0, n;
  logic [7:0] rv [4] = '{8'h04, 8'h3e, 8'h40, 8'h00};
  always #2.5 clk = ~clk;
  vref_ctrl_host u_host (.clk, .wr_en, .rd_en, .addr, .wdata, .rdata_r);
  vref_ctrl_regs #(.STEP_38(5), .DISCH_HOLD(50)) u_dut (.clk, .rst_n,
    .wr_en, .rd_en, .addr, .wdata, .rdata_r, .soft_start_done(ssd),
    .output_overvoltage_fault(flt[1]), .overvoltage_response_select(flt[0]),
    .input_undervoltage_lockout(flt[2]), .pg_out_of_window(pgw),
    .vref_target_r(), .vref_active_r(), .ref_slew_select_r(),
    .output_discharge_force_r(), .dither_enable_r(), .start_reserved_r(),
    .power_good_hold_select_r(), .switching_enable_r(),
    .update_busy_r(), .discharge_on_r(), .power_good_flag_r());
  task check(input string nm, input logic [10:0] s, input logic [10:0] e);
    checks++;
    num_errors += (s !== e);
    if (s !== e) $display("Error %s expected %h seen %h", nm, e, s);
  endtask
  task tally_and_finish(input int late);
    num_errors += late;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial #20000 tally_and_finish(1);
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // unmapped address last, it must read back zero
    for (int i = 0; i < 4; i++)
    begin
      u_host.xfer(1'b0, i == 3 ? 8'h07 : 8'(i), 8'h00);
      check("reg", u_host.q, rv[i]);
    end
    check("ref", u_dut.vref_active_r, 11'h1f4);
    u_host.xfer(1'b1, 8'h01, 8'h3d);
    u_host.xfer(1'b1, 8'h02, 8'h06);
    check("goal", u_dut.vref_target_r, 11'h1ec);
    // slowest slew: 8 steps of 5 cycles each
    for (n = 0; u_dut.update_busy_r === 1'b1 && n < 999; n++) @(posedge clk) #1;
    check("slew", 11'(n > 36 && n < 46), 11'h1);
    check("end", u_dut.vref_active_r, 11'h1ec);
    check("dis", u_dut.discharge_on_r, 1'b1);
    repeat (55) @(posedge clk) #1;
    check("dis", u_dut.discharge_on_r, 1'b0);
    u_host.xfer(1'b1, 8'h02, 8'h3c);
    u_host.xfer(1'b0, 8'h02, 8'h00);
    check("ctl", u_host.q, 8'h3c);
    check("dith", u_dut.dither_enable_r, 1'b1);
    check("dis", u_dut.discharge_on_r, 1'b1);
    check("force", u_dut.output_discharge_force_r, 1'b1);
    check("rsvd", u_dut.start_reserved_r, 1'b1);
    check("hold", u_dut.power_good_hold_select_r, 1'b1);
    check("slew", u_dut.ref_slew_select_r, 11'h0);
    @(posedge clk) pgw <= 1'b1;
    @(posedge clk) pgw <= 1'b0;
    repeat (3) @(posedge clk) #1;
    check("pg", u_dut.power_good_flag_r, 1'b1);
    u_host.xfer(1'b1, 8'h02, 8'hc5);
    check("pg", u_dut.power_good_flag_r, 1'b0);
    check("swen", u_dut.switching_enable_r, 1'b1);
    check("slew", u_dut.ref_slew_select_r, 11'h3);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk) flt <= k == 0 ? 3'h4 : k == 1 ? 3'h3 : 3'h2;
      repeat (2) @(posedge clk) #1;
      check("flt", u_dut.discharge_on_r, 11'(k < 2));
    end
    // during soft-start the ramp ignores the 150 mV/ms slew setting
    @(posedge clk) ssd <= 1'b0;
    u_host.xfer(1'b1, 8'h00, 8'h07);
    u_host.xfer(1'b1, 8'h02, 8'hc7);
    repeat (4) @(posedge clk) #1;
    check("fast", u_dut.vref_active_r, 11'h1ef);
    check("done", u_dut.update_busy_r, 1'b0);
    ssd <= 1'b1;
    tally_and_finish(0);
  end
endmodule
